// *** src/ddr3_mode_regs.v ***
// Purpose: Mode-register functions of a DDR3 memory device: termination, latency,
//          write leveling, self-refresh rate and calibration-register reads.
// Assumes: clock_i at 40 MHz oversamples the controller clock ck_i and all pins.
// Notes: One data lane; a burst beat is taken or driven on each ck_i edge.
// Notes on behaviour
// - Register-one bit 12 low tristates data outputs
// - Nominal termination code picks RZQ divisor
// - Write termination replaces nominal during writes
// - Termination pin delayed by on/off latency
// - Register-one bit 7 enables write leveling
// - Additive latency zero, CL-1 or CL-2
// - Early commands held AL cycles internally
// - Read latency AL+CL, write latency AL+CWL
// - Register-two bits 5:3 give CWL
// - Auto self-refresh scales rate with temperature
// - Self-refresh temperature mode forces double rate
// - Nonzero write-termination code enables dynamic termination
// - Dynamic termination only in writes, not leveling
// - Register-three bit 2 enables calibration register
// - Reads return calibration data while enabled
// - Calibration pattern alternates starting with zero
// - Bank address picks target mode register
`timescale 1ns/1ps
`default_nettype none
`include "ddr3_mode_map.vh"

module ddr3_mode_regs (
   input wire clock_i,
   input wire rstn_i,
   input wire ck_i,
   input wire cs_n_i,
   input wire ras_n_i,
   input wire cas_n_i,
   input wire we_n_i,
   input wire [2:0] ba_i,
   input wire [13:0] addr_i,
   input wire odt_i,
   input wire dq_i,
   input wire [3:0] cas_latency_i,
   input wire temp_hot_i,
   input wire [7:0] array_rdata_i,
   output wire dq_o,
   output wire dq_oe_n_o,
   output wire rd_release_o,
   output wire wr_release_o,
   output wire [7:0] wr_data_o,
   output wire wr_data_valid_o,
   output wire [3:0] rtt_div_o,
   output wire dyn_odt_o,
   output wire wr_level_o,
   output wire outputs_off_o,
   output wire mpr_on_o,
   output wire sr_rate_2x_o,
   output wire [4:0] rl_o,
   output wire [4:0] wl_o
);

   // ----------------------------------------
   // Functions
   // ----------------------------------------
   function [4:0] al_cycles;
      input [1:0] code;
      input [3:0] cl;
      begin
         case (code)
            `AL_CL1: al_cycles = {1'b0, cl} - `AL_CL1_OFS;
            `AL_CL2: al_cycles = {1'b0, cl} - `AL_CL2_OFS;
            default: al_cycles = `LAT_ZERO;
         endcase
      end
   endfunction

   // Latency tap: zero means the command edge itself
   function tap;
      input [`PIPE_W-1:0] vec;
      input [4:0] n;
      input cur;
      begin
         if (n == `LAT_ZERO) begin
            tap = cur;
         end else begin
            tap = vec[n - `LAT_ONE];
         end
      end
   endfunction

   function [3:0] nom_div;
      input [2:0] code;
      begin
         case (code)
            `RTT_NOM_E1: nom_div = `DIV_4;
            `RTT_NOM_E2: nom_div = `DIV_3;
            `RTT_NOM_E3: nom_div = `DIV_6;
            `RTT_NOM_E4: nom_div = `DIV_12;
            `RTT_NOM_E5: nom_div = `DIV_8;
            default: nom_div = `DIV_OFF;
         endcase
      end
   endfunction

   // ----------------------------------------
   // Reset release and pin synchronisers
   // ----------------------------------------
   reg rst_meta_reg;
   reg rst_n_reg;
   always @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_meta_reg <= 1'b0;
         rst_n_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n_reg <= rst_meta_reg;
      end
   end

   localparam SW = 24;
   wire [SW-1:0] pins_in;
   assign pins_in = {ck_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, odt_i, dq_i, ba_i, addr_i};
   reg [SW-1:0] s1_reg;
   reg [SW-1:0] s2_reg;
   reg ck_prev_reg;
   always @(posedge clock_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         s1_reg <= {SW{1'b0}};
         s2_reg <= {SW{1'b0}};
         ck_prev_reg <= 1'b0;
      end else begin
         s1_reg <= pins_in;
         s2_reg <= s1_reg;
         ck_prev_reg <= s2_reg[SW-1];
      end
   end

   wire ck_s;
   wire cs_n_s;
   wire ras_n_s;
   wire cas_n_s;
   wire we_n_s;
   wire odt_s;
   wire dq_s;
   wire [2:0] ba_s;
   wire [13:0] addr_s;
   assign {ck_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, odt_s, dq_s, ba_s, addr_s} = s2_reg;

   wire rise = ck_s & ~ck_prev_reg;
   wire fall = ~ck_s & ck_prev_reg;
   wire edge_any = rise | fall;

   // ----------------------------------------
   // Command decode and mode registers
   // ----------------------------------------
   wire cmd_ok = rise & ~cs_n_s;
   wire [2:0] cmd = {ras_n_s, cas_n_s, we_n_s};
   wire is_mrs = cmd_ok & (cmd == `CMD_MRS);
   wire is_rd = cmd_ok & (cmd == `CMD_READ);
   wire is_wr = cmd_ok & (cmd == `CMD_WRITE);

   reg [`MR_W-1:0] mr1_reg;
   reg [`MR_W-1:0] mr2_reg;
   reg [`MR_W-1:0] mr3_reg;
   // Only a new load changes a register; the base register is served elsewhere
   always @(posedge clock_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         mr1_reg <= `MR_RST;
         mr2_reg <= `MR_RST;
         mr3_reg <= `MR_RST;
      end else if (is_mrs) begin
         if (ba_s == `BA_MR1) begin
            mr1_reg <= addr_s;
         end else if (ba_s == `BA_MR2) begin
            mr2_reg <= addr_s;
         end else if (ba_s == `BA_MR3) begin
            mr3_reg <= addr_s;
         end
      end
   end

   // ----------------------------------------
   // Latencies
   // ----------------------------------------
   wire [4:0] al = al_cycles(mr1_reg[`MR1_AL_HI:`MR1_AL_LO], cas_latency_i);
   wire [4:0] cwl = `CWL_BASE + {2'b00, mr2_reg[`MR2_CWL_HI:`MR2_CWL_LO]};
   wire [4:0] rl = al + {1'b0, cas_latency_i};
   wire [4:0] wl = al + cwl;
   wire [4:0] odt_lat = wl - `ODT_LAT_OFS;

   reg [`PIPE_W-1:0] rd_pipe_reg;
   reg [`PIPE_W-1:0] wr_pipe_reg;
   reg [`PIPE_W-1:0] odt_pipe_reg;
   always @(posedge clock_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         rd_pipe_reg <= {`PIPE_W{1'b0}};
         wr_pipe_reg <= {`PIPE_W{1'b0}};
         odt_pipe_reg <= {`PIPE_W{1'b0}};
      end else if (rise) begin
         rd_pipe_reg <= {rd_pipe_reg[`PIPE_W-2:0], is_rd};
         wr_pipe_reg <= {wr_pipe_reg[`PIPE_W-2:0], is_wr};
         odt_pipe_reg <= {odt_pipe_reg[`PIPE_W-2:0], odt_s};
      end
   end

   // Posted commands leave the pipe after AL controller cycles
   wire rd_release = rise & tap(rd_pipe_reg, al, is_rd);
   wire wr_release = rise & tap(wr_pipe_reg, al, is_wr);
   wire rd_start = rise & tap(rd_pipe_reg, rl, is_rd);
   wire wr_start = rise & tap(wr_pipe_reg, wl, is_wr);

   // ----------------------------------------
   // Read burst and calibration register
   // ----------------------------------------
   wire mpr_on = mr3_reg[`MR3_MPR_EN];
   wire [1:0] mpr_sel = mr3_reg[`MR3_SEL_HI:`MR3_SEL_LO];
   wire [7:0] mpr_data = (mpr_sel == `MPR_SEL_PATTERN) ? `MPR_PATTERN : `MPR_RFU_DATA;
   wire [7:0] rd_src = mpr_on ? mpr_data : array_rdata_i;

   reg [7:0] rd_buf_reg;
   reg [3:0] rd_left_reg;
   reg rd_drive_reg;
   reg dq_reg;
   always @(posedge clock_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         rd_buf_reg <= 8'h00;
         rd_left_reg <= 4'h0;
         rd_drive_reg <= 1'b0;
         dq_reg <= 1'b0;
      end else if (rd_start) begin
         dq_reg <= rd_src[0];
         rd_buf_reg <= {1'b0, rd_src[7:1]};
         rd_left_reg <= `BEATS_LEFT;
         rd_drive_reg <= 1'b1;
      end else if (edge_any) begin
         if (rd_left_reg != 4'h0) begin
            dq_reg <= rd_buf_reg[0];
            rd_buf_reg <= {1'b0, rd_buf_reg[7:1]};
            rd_left_reg <= rd_left_reg - 4'h1;
         end else begin
            rd_drive_reg <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Write burst capture
   // ----------------------------------------
   reg [7:0] wr_buf_reg;
   reg [3:0] wr_left_reg;
   reg [7:0] wr_data_reg;
   reg wr_valid_reg;
   always @(posedge clock_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         wr_buf_reg <= 8'h00;
         wr_left_reg <= 4'h0;
         wr_data_reg <= 8'h00;
         wr_valid_reg <= 1'b0;
      end else begin
         wr_valid_reg <= 1'b0;
         if (wr_start) begin
            wr_buf_reg <= {dq_s, wr_buf_reg[7:1]};
            wr_left_reg <= `BEATS_LEFT;
         end else if (edge_any && wr_left_reg != 4'h0) begin
            wr_buf_reg <= {dq_s, wr_buf_reg[7:1]};
            wr_left_reg <= wr_left_reg - 4'h1;
            if (wr_left_reg == 4'h1) begin
               wr_data_reg <= {dq_s, wr_buf_reg[7:1]};
               wr_valid_reg <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------
   // Termination and mode outputs
   // ----------------------------------------
   wire [2:0] nom_code = {mr1_reg[`MR1_RTT_HI], mr1_reg[`MR1_RTT_MID], mr1_reg[`MR1_RTT_LO]};
   wire [1:0] wr_code = mr2_reg[`MR2_RTTWR_HI:`MR2_RTTWR_LO];
   wire nom_en = nom_code != `RTT_NOM_OFF;
   wire dyn_en = wr_code != `RTT_WR_OFF;
   wire wlev = mr1_reg[`MR1_WLEV];
   wire wr_busy = wr_start | (wr_left_reg != 4'h0);
   wire [3:0] wr_div = (wr_code == `RTT_WR_E1) ? `DIV_4 :
                       (wr_code == `RTT_WR_E2) ? `DIV_2 : `DIV_OFF;

   reg term_on_reg;
   reg [3:0] rtt_reg;
   reg dyn_reg;
   reg rd_rel_reg;
   reg wr_rel_reg;
   reg [4:0] rl_reg;
   reg [4:0] wl_reg;
   reg sr2x_reg;
   always @(posedge clock_i or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         term_on_reg <= 1'b0;
         rtt_reg <= `DIV_OFF;
         dyn_reg <= 1'b0;
         rd_rel_reg <= 1'b0;
         wr_rel_reg <= 1'b0;
         rl_reg <= `LAT_ZERO;
         wl_reg <= `LAT_ZERO;
         sr2x_reg <= 1'b0;
      end else begin
         if (rise) begin
            term_on_reg <= tap(odt_pipe_reg, odt_lat, odt_s);
         end
         // Write leveling keeps the nominal value only
         if (wr_busy && dyn_en && !wlev) begin
            rtt_reg <= wr_div;
            dyn_reg <= 1'b1;
         end else if (term_on_reg && nom_en && !rd_drive_reg) begin
            rtt_reg <= nom_div(nom_code);
            dyn_reg <= 1'b0;
         end else begin
            rtt_reg <= `DIV_OFF;
            dyn_reg <= 1'b0;
         end
         rd_rel_reg <= rd_release;
         wr_rel_reg <= wr_release;
         rl_reg <= rl;
         wl_reg <= wl;
         sr2x_reg <= mr2_reg[`MR2_SRT] | (mr2_reg[`MR2_ASR] & temp_hot_i);
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // Bit 12 low means the drivers stay off, even during a read burst
   assign dq_oe_n_o = ~(rd_drive_reg & mr1_reg[`MR1_QOFF]);
   assign outputs_off_o = ~mr1_reg[`MR1_QOFF];
   assign dq_o = dq_reg;
   assign rd_release_o = rd_rel_reg;
   assign wr_release_o = wr_rel_reg;
   assign wr_data_o = wr_data_reg;
   assign wr_data_valid_o = wr_valid_reg;
   assign rtt_div_o = rtt_reg;
   assign dyn_odt_o = dyn_reg;
   assign wr_level_o = wlev;
   assign mpr_on_o = mpr_on;
   assign sr_rate_2x_o = sr2x_reg;
   assign rl_o = rl_reg;
   assign wl_o = wl_reg;

endmodule // ddr3_mode_regs

`default_nettype wire

// *** src/ddr3_mode_map.vh ***
// Purpose: Constants for the DDR3 mode-register and calibration-register block.
// Assumes: Included by bare name; definitions only.
// Notes: Bit positions refer to the address bus captured by a mode-register-set command.
`ifndef DDR3_MODE_MAP_VH
`define DDR3_MODE_MAP_VH

// ----------------------------------------
// Mode register storage
// ----------------------------------------
`define MR_W 14
`define MR_RST 14'h0000
`define BA_MR1 3'h1
`define BA_MR2 3'h2
`define BA_MR3 3'h3

// ----------------------------------------
// Command codes {ras_n, cas_n, we_n}
// ----------------------------------------
`define CMD_MRS 3'h0
`define CMD_WRITE 3'h4
`define CMD_READ 3'h5

// ----------------------------------------
// Register one fields
// ----------------------------------------
`define MR1_QOFF 12
`define MR1_RTT_HI 9
`define MR1_WLEV 7
`define MR1_RTT_MID 6
`define MR1_AL_HI 4
`define MR1_AL_LO 3
`define MR1_RTT_LO 2

// ----------------------------------------
// Register two and three fields
// ----------------------------------------
`define MR2_RTTWR_HI 10
`define MR2_RTTWR_LO 9
`define MR2_SRT 7
`define MR2_ASR 6
`define MR2_CWL_HI 5
`define MR2_CWL_LO 3
`define MR3_MPR_EN 2
`define MR3_SEL_HI 1
`define MR3_SEL_LO 0

// ----------------------------------------
// Encodings
// ----------------------------------------
`define AL_ZERO 2'h0
`define AL_CL1 2'h1
`define AL_CL2 2'h2
`define AL_CL1_OFS 5'h01
`define AL_CL2_OFS 5'h02
`define CWL_BASE 5'h05
`define ODT_LAT_OFS 5'h02
`define RTT_NOM_OFF 3'h0
`define RTT_NOM_E1 3'h1
`define RTT_NOM_E2 3'h2
`define RTT_NOM_E3 3'h3
`define RTT_NOM_E4 3'h4
`define RTT_NOM_E5 3'h5
`define RTT_WR_OFF 2'h0
`define RTT_WR_E1 2'h1
`define RTT_WR_E2 2'h2
`define DIV_OFF 4'h0
`define DIV_2 4'h2
`define DIV_3 4'h3
`define DIV_4 4'h4
`define DIV_6 4'h6
`define DIV_8 4'h8
`define DIV_12 4'hc
`define MPR_SEL_PATTERN 2'h0
`define MPR_PATTERN 8'haa
`define MPR_RFU_DATA 8'h00

// ----------------------------------------
// Pipelines and bursts
// ----------------------------------------
`define PIPE_W 32
`define BEATS_LEFT 4'h7
`define LAT_ZERO 5'h00
`define LAT_ONE 5'h01

`endif

// *** verif/mode_regs_props.sv ***
// Purpose: Assertions for the mode register block
// Assumes: Command pins steady around each ck_i rise
// Notes: Shadows the mode registers from raw pins
`timescale 1ns/1ps
`default_nettype none
`include "ddr3_mode_map.vh"
module mode_regs_props (
   input wire logic clock_i,
   input wire logic rstn_i,
   input wire logic ck_i,
   input wire logic cs_n_i,
   input wire logic ras_n_i,
   input wire logic cas_n_i,
   input wire logic we_n_i,
   input wire logic [2:0] ba_i,
   input wire logic [13:0] addr_i,
   input wire logic [3:0] cas_latency_i,
   input wire logic temp_hot_i,
   input wire logic dq_oe_n_o,
   input wire logic rd_release_o,
   input wire logic wr_release_o,
   input wire logic [3:0] rtt_div_o,
   input wire logic dyn_odt_o,
   input wire logic wr_level_o,
   input wire logic outputs_off_o,
   input wire logic mpr_on_o,
   input wire logic sr_rate_2x_o,
   input wire logic [4:0] rl_o,
   input wire logic [4:0] wl_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rstn_i);
   logic ck_q;
   logic [13:0] m1, m2, m3;
   logic [3:0] quiet;
   logic [8:0] since_rd;
   logic [8:0] since_wr;
   wire [2:0] cmd = {ras_n_i, cas_n_i, we_n_i};
   wire hit = ck_i & !ck_q & !cs_n_i;
   wire settled = quiet > 4'h7;
   wire [4:0] cl = {1'b0, cas_latency_i};
   wire [4:0] al = m1[4:3] == `AL_CL1 ? cl - 5'h1 : m1[4:3] == `AL_CL2 ? cl - 5'h2 : 5'h0;
   wire [8:0] rel = {1'b0, al, 3'h0};
   wire [3:0] wdiv = m2[10:9] == 2'h1 ? 4'h4 : m2[10:9] == 2'h2 ? 4'h2 : 4'h0;
   // -----------------------------
   // Shadow registers
   // -----------------------------
   // Outputs lag the pins by the synchroniser, so the flag, latency and refresh-rate checks wait for quiet
   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ck_q <= 1'b0;
         {m1, m2, m3} <= 42'h0;
         quiet <= 4'h0;
         since_rd <= 9'h1ff;
         since_wr <= 9'h1ff;
      end else begin
         ck_q <= ck_i;
         quiet <= quiet + {3'h0, quiet != 4'hf};
         since_rd <= since_rd + {8'h0, since_rd != 9'h1ff};
         since_wr <= since_wr + {8'h0, since_wr != 9'h1ff};
         if (hit && cmd == `CMD_READ) since_rd <= 9'h0;
         if (hit && cmd == `CMD_WRITE) since_wr <= 9'h0;
         if (hit && cmd == `CMD_MRS) begin
            quiet <= 4'h0;
            if (ba_i == `BA_MR1) m1 <= addr_i;
            if (ba_i == `BA_MR2) m2 <= addr_i;
            if (ba_i == `BA_MR3) m3 <= addr_i;
         end
      end
   end
   // -----------------------------
   // Properties
   // -----------------------------
   property p_qoff; outputs_off_o |-> dq_oe_n_o; endproperty
   a_qoff: assert property (p_qoff) else $error("outputs driven while disabled");
   property p_wlev; settled |-> wr_level_o == m1[7]; endproperty
   a_wlev: assert property (p_wlev) else $error("leveling flag wrong");
   property p_mpr; settled |-> mpr_on_o == m3[2]; endproperty
   a_mpr: assert property (p_mpr) else $error("calibration flag wrong");
   property p_rl; settled && $stable(cas_latency_i) |-> rl_o == al + cl; endproperty
   a_rl: assert property (p_rl) else $error("read latency wrong");
   property p_wl;
      settled && $stable(cas_latency_i) |-> wl_o == al + `CWL_BASE + {2'h0, m2[5:3]};
   endproperty
   a_wl: assert property (p_wl) else $error("write latency wrong");
   property p_srt; settled && m2[7] |-> sr_rate_2x_o; endproperty
   a_srt: assert property (p_srt) else $error("forced rate missing");
   property p_asr;
      (settled && !m2[7] && $stable(temp_hot_i))[*3] |-> sr_rate_2x_o == (m2[6] & temp_hot_i);
   endproperty
   a_asr: assert property (p_asr) else $error("auto rate wrong");
   property p_dyn; dyn_odt_o |-> m2[10:9] != 2'h0 && !wr_level_o; endproperty
   a_dyn: assert property (p_dyn) else $error("write termination not allowed");
   property p_div; dyn_odt_o && $past(dyn_odt_o) |-> rtt_div_o == wdiv; endproperty
   a_div: assert property (p_div) else $error("write divisor wrong");
   property p_rel; $rose(rd_release_o) |-> since_rd > rel && since_rd < rel + 9'h6; endproperty
   a_rel: assert property (p_rel) else $error("read release off its latency");
   property p_wrel; $rose(wr_release_o) |-> since_wr > rel && since_wr < rel + 9'h6; endproperty
   a_wrel: assert property (p_wrel) else $error("write release off its latency");
endmodule // mode_regs_props
bind ddr3_mode_regs mode_regs_props chk_u (.clock_i, .rstn_i, .ck_i, .cs_n_i, .ras_n_i,
   .cas_n_i, .we_n_i, .ba_i, .addr_i, .cas_latency_i, .temp_hot_i, .dq_oe_n_o, .rd_release_o,
   .wr_release_o, .rtt_div_o, .dyn_odt_o, .wr_level_o, .outputs_off_o, .mpr_on_o,
   .sr_rate_2x_o, .rl_o, .wl_o);
`default_nettype wire

// *** verif/ddr3_ctrl_model.sv ***
// Purpose: Controller model driving clock, commands and write data
// Assumes: Free running ck_o of 200 ns
// Notes: Released bank, address and data lines show the inverse of their last value; command lines go high
`timescale 1ns/1ps
`default_nettype none
module ddr3_ctrl_model (
   output logic ck_o,
   output logic cs_n_o,
   output logic ras_n_o,
   output logic cas_n_o,
   output logic we_n_o,
   output logic [2:0] ba_o,
   output logic [13:0] addr_o,
   output logic odt_o,
   output logic dq_o
);
   initial begin
      {cs_n_o, ras_n_o, cas_n_o, we_n_o, ba_o, addr_o, odt_o, dq_o} = 23'h780000;
      ck_o = 1'b0;
      forever #100 ck_o = ~ck_o;
   end
   // Pins move on the falling edge so they are steady across the rise
   task automatic issue(input logic [2:0] c, input logic [2:0] b, input logic [13:0] a);
      @(negedge ck_o);
      {cs_n_o, ras_n_o, cas_n_o, we_n_o, ba_o, addr_o} <= {1'b0, c, b, a};
      @(negedge ck_o);
      {cs_n_o, ras_n_o, cas_n_o, we_n_o, ba_o, addr_o} <= {4'hf, ~b, ~a};
   endtask
   task automatic set_odt(input logic v);
      @(negedge ck_o);
      odt_o <= v;
   endtask
   // Beat centred on each ck edge from write latency on
   task automatic burst(input int wl, input logic [7:0] d);
      #(200 * wl - 150);
      for (int i = 0; i < 8; i++) begin
         dq_o <= d[i];
         #100;
      end
      dq_o <= ~d[7];
   endtask
endmodule // ddr3_ctrl_model
`default_nettype wire

// *** verif/tb_ddr3_mode_regs.sv ***
// Purpose: Self-checking bench for the mode register block
// Assumes: Controller model drives the command side
// Notes: Bursts are checked through expectation queues
`timescale 1ns/1ps
`default_nettype none
`include "ddr3_mode_map.vh"
module tb_ddr3_mode_regs;
   logic clock_i, rstn_i, ck_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, odt_i, dq_i, temp_hot_i;
   logic [2:0] ba_i;
   logic [13:0] addr_i;
   logic [3:0] cas_latency_i;
   logic [7:0] array_rdata_i;
   wire dq_o, dq_oe_n_o, wr_data_valid_o, dyn_odt_o, wr_level_o, outputs_off_o, mpr_on_o;
   wire sr_rate_2x_o;
   wire [7:0] wr_data_o;
   wire [3:0] rtt_div_o;
   int error_cnt = 0;
   int checked = 0;
   int cycles = 0;
   int rd_cnt = 0;
   logic dyn_seen = 1'b0;
   logic [31:0] seed = 32'h15a17aed;
   logic [7:0] rd_q[$];
   logic [7:0] wr_q[$];
   time t_q[$];
   localparam logic [3:0] NOM_DIV [8] = '{4'h0, 4'h4, 4'h3, 4'h6, 4'hc, 4'h8, 4'h0, 4'h0};
   ddr3_ctrl_model ctrl_u (.ck_o(ck_i), .cs_n_o(cs_n_i), .ras_n_o(ras_n_i), .cas_n_o(cas_n_i),
      .we_n_o(we_n_i), .ba_o(ba_i), .addr_o(addr_i), .odt_o(odt_i), .dq_o(dq_i));
   ddr3_mode_regs dut_u (.clock_i, .rstn_i, .ck_i, .cs_n_i, .ras_n_i, .cas_n_i, .we_n_i, .ba_i,
      .addr_i, .odt_i, .dq_i, .cas_latency_i, .temp_hot_i, .array_rdata_i, .dq_o, .dq_oe_n_o,
      .rd_release_o(), .wr_release_o(), .wr_data_o, .wr_data_valid_o, .rtt_div_o, .dyn_odt_o,
      .wr_level_o, .outputs_off_o, .mpr_on_o, .sr_rate_2x_o, .rl_o(), .wl_o());
   // -----------------------------
   // Helpers
   // -----------------------------
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic close_out();
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Loads only while no burst runs
   task automatic mrs(input logic [2:0] b, input logic [13:0] a);
      ctrl_u.issue(`CMD_MRS, b, a);
      repeat (4) @(posedge ck_i);
   endtask
   task automatic rd(input logic [7:0] exp, input int rl);
      ctrl_u.issue(`CMD_READ, 3'h0, 14'h0);
      rd_q.push_back(exp);
      t_q.push_back($time - 100 + rl * 200);
      repeat (rl + 8) @(posedge ck_i);
   endtask
   task automatic wr(input logic [7:0] d, input int wl);
      ctrl_u.issue(`CMD_WRITE, 3'h0, 14'h0);
      wr_q.push_back(d);
      ctrl_u.burst(wl, d);
      repeat (6) @(posedge ck_i);
   endtask
   // -----------------------------
   // Clock, timeout and monitors
   // -----------------------------
   initial begin
      clock_i = 1'b0;
      forever #12.5 clock_i = ~clock_i;
   end
   always @(posedge clock_i) begin
      cycles++;
      if (dyn_odt_o === 1'b1) dyn_seen <= 1'b1;
      if (wr_data_valid_o === 1'b1 && wr_q.size() == 0) begin
         error_cnt++;
         $display("mismatch write expected none seen %h", wr_data_o);
      end else if (wr_data_valid_o === 1'b1) begin
         check("write", wr_q.pop_front(), wr_data_o);
      end
      if (cycles == 20000) begin
         error_cnt++;
         close_out();
      end
   end
   always @(negedge dq_oe_n_o) begin : rd_mon
      logic [7:0] v;
      time d;
      d = $time - (t_q.size() > 0 ? t_q.pop_front() : 0);
      check("read delay", 8'h1, {7'h0, d >= 50 && d <= 125});
      #50;
      for (int i = 0; i < 8; i++) begin
         v[i] = dq_o;
         #100;
      end
      rd_cnt++;
      if (rd_q.size() == 0) begin
         error_cnt++;
         $display("mismatch read expected none seen %h", v);
      end else begin
         check("read", rd_q.pop_front(), v);
      end
   end
   // -----------------------------
   // Scenarios
   // -----------------------------
   initial begin
      {rstn_i, temp_hot_i, cas_latency_i, array_rdata_i} = 14'h0600;
      repeat (10) @(posedge clock_i);
      rstn_i <= 1'b1;
      repeat (8) @(posedge ck_i);
      check("outputs off", 8'h1, {7'h0, outputs_off_o & dq_oe_n_o});
      ctrl_u.issue(`CMD_READ, 3'h0, 14'h0);
      repeat (20) @(posedge ck_i);
      check("bursts while off", 8'h0, 8'(rd_cnt));
      mrs(3'h0, 14'h1080);
      mrs(3'h5, 14'h1080);
      check("ignored loads", 8'h1, {6'h0, wr_level_o, outputs_off_o});
      $display("test disable done");
      for (int c = 0; c < 8; c++) begin
         mrs(`BA_MR1, 14'h1000 | {4'h0, c[2], 2'h0, c[1], 3'h0, c[0], 2'h0});
         ctrl_u.set_odt(1'b1);
         repeat (12) @(posedge ck_i);
         check("nominal", {4'h0, NOM_DIV[c]}, {4'h0, rtt_div_o});
         ctrl_u.set_odt(1'b0);
         repeat (12) @(posedge ck_i);
         check("idle", 8'h0, {4'h0, rtt_div_o});
      end
      $display("test termination done");
      for (int a = 0; a < 3; a++) begin
         @(posedge clock_i);
         array_rdata_i <= 8'(rnd());
         mrs(`BA_MR1, {9'h080, a[1:0], 3'h0});
         rd(array_rdata_i, 6 + (a == 0 ? 0 : 6 - a));
      end
      mrs(`BA_MR3, 14'h0004);
      check("calibration on", 8'h1, {7'h0, mpr_on_o});
      rd(8'haa, 10);
      rd(8'haa, 10);
      mrs(`BA_MR3, 14'h0005);
      rd(8'h00, 10);
      mrs(`BA_MR3, 14'h0007);
      rd(8'h00, 10);
      mrs(`BA_MR3, 14'h0000);
      rd(array_rdata_i, 10);
      $display("test reads done");
      ctrl_u.set_odt(1'b1);
      for (int i = 0; i < 5; i++) begin
         dyn_seen <= 1'b0;
         mrs(`BA_MR1, i == 4 ? 14'h10c0 : 14'h1040);
         mrs(`BA_MR2, {3'h0, i[1:0] | {1'b0, i[2]}, 3'h0, 1'b0, i[1:0], 3'h0});
         wr(8'(rnd()), 5 + i[1:0]);
         check("dynamic", {7'h0, i != 0 && i != 4}, {7'h0, dyn_seen});
         check("after write", 8'h3, {4'h0, rtt_div_o});
      end
      ctrl_u.set_odt(1'b0);
      $display("test writes done");
      for (int i = 0; i < 8; i++) begin
         if (i[2:1] == 2'h3) continue;
         @(posedge clock_i);
         temp_hot_i <= i[0];
         mrs(`BA_MR2, {6'h0, i[2:1], 6'h0});
         check("rate", {7'h0, i[2] | (i[1] & i[0])}, {7'h0, sr_rate_2x_o});
      end
      $display("test refresh done");
      check("leftover", 8'h0, 8'(rd_q.size() + wr_q.size()));
      close_out();
   end
endmodule // tb_ddr3_mode_regs
`default_nettype wire
